/* File: hw/vme_decode_pkg.sv */
`default_nettype none
package vme_decode_pkg;
    // Address modifiers
    localparam logic [5:0] AM_A24_UD = 6'h39;
    localparam logic [5:0] AM_A24_UP = 6'h3a;
    localparam logic [5:0] AM_A24_SD = 6'h3d;
    localparam logic [5:0] AM_A24_SP = 6'h3e;
    localparam logic [5:0] AM_A24_UB = 6'h3b;
    localparam logic [5:0] AM_A24_SB = 6'h3f;
    localparam logic [5:0] AM_CRCSR  = 6'h2f;
    localparam logic [5:0] AM_A32_UD = 6'h09;
    localparam logic [5:0] AM_A32_UP = 6'h0a;
    localparam logic [5:0] AM_A32_SD = 6'h0d;
    localparam logic [5:0] AM_A32_SP = 6'h0e;
    localparam logic [5:0] AM_A32_UB = 6'h0b;
    localparam logic [5:0] AM_A32_SB = 6'h0f;
    localparam logic [5:0] AM_A32_UM = 6'h08;
    localparam logic [5:0] AM_A32_SM = 6'h0c;
    localparam logic [5:0] AM_2E     = 6'h20;
    // Extended modifiers carried in address byte 0
    localparam logic [7:0] XAM_2EVME = 8'h01;
    localparam logic [7:0] XAM_2ESST = 8'h11;
    // Register offsets inside the A24 window
    localparam logic [17:0] OFS_WIN_BASE  = 18'h00180;
    localparam logic [17:0] OFS_TEST_BASE = 18'h00188;
    localparam logic [17:0] OFS_FIBER     = 18'h00190;
    localparam logic [17:0] OFS_OBUF      = 18'h00194;
    localparam logic [17:0] OFS_SDRAM     = 18'h00198;
    localparam logic [17:0] OFS_BANK      = 18'h0019c;
    localparam logic [17:0] OFS_CFG_LO    = 18'h00180;
    localparam logic [17:0] OFS_CFG_HI    = 18'h0019c;
    // Reset values
    localparam logic [7:0]  RST_WIN_BASE  = 8'h00;
    localparam logic [31:0] RST_A32_BASE  = 32'h00000000;
    localparam logic [3:0]  RST_BANK      = 4'h0;
    // Field positions and widths
    localparam int W_A24      = 6;
    localparam int W_A32      = 9;
    localparam int A24_LSB    = 18;
    localparam int A32_LSB    = 23;
    localparam int BASE_LSB   = 21;
    localparam int CSR_LSB    = 19;
    // Address steps of block beats
    localparam logic [31:0] STEP_D32 = 32'h00000004;
    localparam logic [31:0] STEP_D64 = 32'h00000008;

    typedef enum {SP_NONE, SP_CFG, SP_A24, SP_CRCSR,
                  SP_OBUF, SP_SDRAM, SP_TEST} space_t;
    typedef enum {CY_SINGLE, CY_BLT, CY_D64} cyc_t;
    typedef enum {ST_IDLE, ST_DEC, ST_WAIT, ST_REG,
                  ST_LOC, ST_ACK, ST_SKIP} state_t;
endpackage
`default_nettype wire

/* File: hw/vme_slave_address_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module vme_slave_address_decode
    import vme_decode_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Bus address, modifier, strobes
    input  wire logic [31:0] al_in,
    output logic      [31:0] al_o,
    output logic             al_oe_n,
    input  wire logic [5:0]  am_in,
    input  wire logic        as_n,
    input  wire logic [1:0]  ds_n,
    input  wire logic        write_n,
    // Bus data
    input  wire logic [31:0] d_in,
    output logic      [31:0] d_o,
    output logic             d_oe_n,
    // Bus answer lines
    output logic             dtack_oe_n,
    output logic             berr_oe_n,
    // Slot position
    input  wire logic [4:0]  slot_position_lines,
    input  wire logic        slot_position_parity,
    // Board-side access
    output logic             loc_req,
    output logic             loc_wr,
    output space_t           loc_space,
    output logic      [22:0] loc_addr,
    output logic      [63:0] loc_wdata,
    input  wire logic [63:0] loc_rdata,
    input  wire logic        loc_ack,
    input  wire logic        loc_last,
    // Optical link register gate
    input  wire logic        fib_req,
    input  wire logic [17:0] fib_addr,
    output logic             fib_grant,
    // Control outputs
    output logic             fiber_disable,
    output logic             tx_disable,
    output logic             fiber_reset,
    output logic      [3:0]  sdram_bank
);
    state_t      state, next_state;
    space_t      space_q, next_space, dec_space, next_loc_space;
    cyc_t        cyc_q, next_cyc, dec_cyc;
    logic [31:0] addr_q, next_addr;
    logic [5:0]  am_q, next_am;
    logic        wr_q, next_wr;
    logic [7:0]  win_base, next_win_base;
    logic        base_loaded, next_base_loaded;
    logic [31:0] obuf_base, next_obuf_base;
    logic [31:0] sdram_base, next_sdram_base;
    logic [31:0] test_base, next_test_base;
    logic [31:0] reg_rd;
    logic [31:0] next_al_o, next_d_o;
    logic        next_al_oe_n, next_d_oe_n;
    logic        next_dtack_oe_n, next_berr_oe_n;
    logic        next_loc_req, next_loc_wr, next_fib_grant;
    logic [22:0] next_loc_addr;
    logic [63:0] next_loc_wdata;
    logic        next_fiber_disable, next_tx_disable, next_fiber_reset;
    logic [3:0]  next_sdram_bank;
    logic        am_a24, am_a24_blt, am_a32, am_a32_blt, am_mblt, am_2e;
    logic        fib_protected;
    logic [17:0] offset;

    // Window compares on the latched address
    window_if #(.W(W_A24)) a24_if ();
    window_if #(.W(W_A32)) obuf_if ();
    window_if #(.W(W_A32)) sdram_if ();
    window_if #(.W(W_A32)) test_if ();
    assign a24_if.addr_hi   = addr_q[A24_LSB+W_A24-1:A24_LSB];
    assign a24_if.base_hi   = win_base[7:2];
    assign obuf_if.addr_hi  = addr_q[A32_LSB+W_A32-1:A32_LSB];
    assign obuf_if.base_hi  = obuf_base[BASE_LSB+W_A32-1:BASE_LSB];
    assign sdram_if.addr_hi = addr_q[A32_LSB+W_A32-1:A32_LSB];
    assign sdram_if.base_hi = sdram_base[BASE_LSB+W_A32-1:BASE_LSB];
    assign test_if.addr_hi  = addr_q[A32_LSB+W_A32-1:A32_LSB];
    assign test_if.base_hi  = test_base[BASE_LSB+W_A32-1:BASE_LSB];
    window_match #(.W(W_A24)) a24_m   (.win(a24_if.matcher));
    window_match #(.W(W_A32)) obuf_m  (.win(obuf_if.matcher));
    window_match #(.W(W_A32)) sdram_m (.win(sdram_if.matcher));
    window_match #(.W(W_A32)) test_m  (.win(test_if.matcher));

    // Modifier classes and space decode
    always_comb begin
        offset     = addr_q[17:0];
        am_a24     = am_q inside {AM_A24_UD, AM_A24_UP,
                                  AM_A24_SD, AM_A24_SP};
        am_a24_blt = am_q inside {AM_A24_UB, AM_A24_SB};
        am_a32     = am_q inside {AM_A32_UD, AM_A32_UP,
                                  AM_A32_SD, AM_A32_SP};
        am_a32_blt = am_q inside {AM_A32_UB, AM_A32_SB};
        am_mblt    = am_q inside {AM_A32_UM, AM_A32_SM};
        am_2e      = (am_q == AM_2E) && (addr_q[7:0] == XAM_2EVME
                     || addr_q[7:0] == XAM_2ESST);
        dec_cyc    = (am_mblt || am_2e) ? CY_D64 :
                     (am_a24_blt || am_a32_blt) ? CY_BLT : CY_SINGLE;
        dec_space  = SP_NONE;
        if ((am_a24 || am_a24_blt) && a24_if.hit) begin
            if (am_a24 && offset >= OFS_CFG_LO && offset <= OFS_CFG_HI)
                dec_space = SP_CFG;
            else
                dec_space = SP_A24;
        end else if (am_q == AM_CRCSR &&
                     addr_q[CSR_LSB+4:CSR_LSB] == slot_position_lines) begin
            dec_space = SP_CRCSR;
        end else if (am_a32 || am_a32_blt || am_mblt || am_2e) begin
            if (obuf_if.hit)
                dec_space = SP_OBUF;
            else if (sdram_if.hit)
                dec_space = SP_SDRAM;
            else if (test_if.hit)
                dec_space = SP_TEST;
        end
        fib_protected = fib_addr >= OFS_CFG_LO && fib_addr <= OFS_CFG_HI;
    end

    // Register readback
    always_comb begin
        reg_rd = 32'h00000000;
        case (offset)
            OFS_WIN_BASE:  reg_rd = {24'h000000, win_base};
            OFS_TEST_BASE: reg_rd = test_base;
            OFS_FIBER:     reg_rd = {28'h0000000, fiber_reset, 1'b0,
                                     tx_disable, fiber_disable};
            OFS_OBUF:      reg_rd = obuf_base;
            OFS_SDRAM:     reg_rd = sdram_base;
            OFS_BANK:      reg_rd = {28'h0000000, sdram_bank};
            default:       reg_rd = 32'h00000000;
        endcase
    end

    // Cycle sequencer and registers, next values
    always_comb begin
        next_state         = state;
        next_space         = space_q;
        next_cyc           = cyc_q;
        next_addr          = addr_q;
        next_am            = am_q;
        next_wr            = wr_q;
        next_win_base      = win_base;
        next_base_loaded   = base_loaded;
        next_obuf_base     = obuf_base;
        next_sdram_base    = sdram_base;
        next_test_base     = test_base;
        next_al_o          = al_o;
        next_al_oe_n       = al_oe_n;
        next_d_o           = d_o;
        next_d_oe_n        = d_oe_n;
        next_dtack_oe_n    = dtack_oe_n;
        next_berr_oe_n     = berr_oe_n;
        next_loc_req       = 1'b0;
        next_loc_wr        = loc_wr;
        next_loc_space     = loc_space;
        next_loc_addr      = loc_addr;
        next_loc_wdata     = loc_wdata;
        next_fiber_disable = fiber_disable;
        next_tx_disable    = tx_disable;
        next_fiber_reset   = fiber_reset;
        next_sdram_bank    = sdram_bank;
        next_fib_grant     = fib_req && !fib_protected;
        // Slot bits caught once after reset release
        if (!base_loaded) begin
            next_win_base    = {slot_position_lines, 3'h0};
            next_base_loaded = 1'b1;
        end
        case (state)
            ST_IDLE: begin
                if (!as_n) begin
                    next_addr  = al_in;
                    next_am    = am_in;
                    next_wr    = !write_n;
                    next_state = ST_DEC;
                end
            end
            ST_DEC: begin
                next_space = dec_space;
                next_cyc   = dec_cyc;
                next_state = (dec_space == SP_NONE) ? ST_SKIP : ST_WAIT;
            end
            ST_WAIT: begin
                if (as_n) begin
                    next_state = ST_IDLE;
                end else if (ds_n != 2'h3) begin
                    next_loc_wdata = {al_in, d_in};
                    if (space_q == SP_CFG) begin
                        next_state = ST_REG;
                    end else if (!fiber_disable) begin
                        next_dtack_oe_n = 1'b0;
                        next_berr_oe_n  = 1'b0;
                        next_state      = ST_ACK;
                    end else begin
                        next_loc_req   = 1'b1;
                        next_loc_wr    = wr_q;
                        next_loc_space = space_q;
                        next_loc_addr  = (space_q == SP_A24) ?
                            {5'h00, addr_q[17:0]} : addr_q[22:0];
                        next_state     = ST_LOC;
                    end
                end
            end
            ST_REG: begin
                if (wr_q) begin
                    case (offset)
                        OFS_WIN_BASE:  next_win_base = d_in[7:0];
                        OFS_TEST_BASE: next_test_base = d_in;
                        OFS_FIBER: begin
                            next_fiber_disable = d_in[0];
                            next_tx_disable    = d_in[1];
                            next_fiber_reset   = d_in[3];
                        end
                        OFS_OBUF:      next_obuf_base = d_in;
                        OFS_SDRAM:     next_sdram_base = d_in;
                        OFS_BANK:      next_sdram_bank = d_in[3:0];
                        default:       next_state = ST_REG;
                    endcase
                end
                next_d_o        = reg_rd;
                next_d_oe_n     = wr_q;
                next_dtack_oe_n = 1'b0;
                next_state      = ST_ACK;
            end
            ST_LOC: begin
                if (loc_ack) begin
                    next_d_o        = loc_rdata[31:0];
                    next_al_o       = loc_rdata[63:32];
                    next_d_oe_n     = wr_q;
                    next_al_oe_n    = wr_q || cyc_q != CY_D64;
                    next_dtack_oe_n = 1'b0;
                    if (loc_last && am_q == AM_2E)
                        next_berr_oe_n = 1'b0;
                    next_state      = ST_ACK;
                end
            end
            ST_ACK: begin
                if (ds_n == 2'h3) begin
                    next_dtack_oe_n = 1'b1;
                    next_berr_oe_n  = 1'b1;
                    next_d_oe_n     = 1'b1;
                    next_al_oe_n    = 1'b1;
                    if (!berr_oe_n) begin
                        next_state = ST_SKIP;
                    end else begin
                        if (cyc_q == CY_D64)
                            next_addr = addr_q + STEP_D64;
                        else if (cyc_q == CY_BLT)
                            next_addr = addr_q + STEP_D32;
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_SKIP: begin
                if (as_n)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Register stage
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state         <= ST_IDLE;
            space_q       <= SP_NONE;
            cyc_q         <= CY_SINGLE;
            addr_q        <= RST_A32_BASE;
            am_q          <= 6'h00;
            wr_q          <= 1'b0;
            win_base      <= RST_WIN_BASE;
            base_loaded   <= 1'b0;
            obuf_base     <= RST_A32_BASE;
            sdram_base    <= RST_A32_BASE;
            test_base     <= RST_A32_BASE;
            al_o          <= 32'h00000000;
            al_oe_n       <= 1'b1;
            d_o           <= 32'h00000000;
            d_oe_n        <= 1'b1;
            dtack_oe_n    <= 1'b1;
            berr_oe_n     <= 1'b1;
            loc_req       <= 1'b0;
            loc_wr        <= 1'b0;
            loc_space     <= SP_NONE;
            loc_addr      <= 23'h000000;
            loc_wdata     <= 64'h0000000000000000;
            fib_grant     <= 1'b0;
            fiber_disable <= 1'b0;
            tx_disable    <= 1'b0;
            fiber_reset   <= 1'b0;
            sdram_bank    <= RST_BANK;
        end else begin
            state         <= next_state;
            space_q       <= next_space;
            cyc_q         <= next_cyc;
            addr_q        <= next_addr;
            am_q          <= next_am;
            wr_q          <= next_wr;
            win_base      <= next_win_base;
            base_loaded   <= next_base_loaded;
            obuf_base     <= next_obuf_base;
            sdram_base    <= next_sdram_base;
            test_base     <= next_test_base;
            al_o          <= next_al_o;
            al_oe_n       <= next_al_oe_n;
            d_o           <= next_d_o;
            d_oe_n        <= next_d_oe_n;
            dtack_oe_n    <= next_dtack_oe_n;
            berr_oe_n     <= next_berr_oe_n;
            loc_req       <= next_loc_req;
            loc_wr        <= next_loc_wr;
            loc_space     <= next_loc_space;
            loc_addr      <= next_loc_addr;
            loc_wdata     <= next_loc_wdata;
            fib_grant     <= next_fib_grant;
            fiber_disable <= next_fiber_disable;
            tx_disable    <= next_tx_disable;
            fiber_reset   <= next_fiber_reset;
            sdram_bank    <= next_sdram_bank;
        end
    end

    // Checks
    AST_NO_ACK_OFF_WINDOW: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_DEC && dec_space == SP_NONE)
        |=> (state == ST_SKIP) [*2])
        else $error("Cycle outside every window was taken");
    AST_BASE_FROM_SLOT: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(base_loaded) |-> win_base == {$past(slot_position_lines), 3'h0})
        else $error("Window base not loaded from slot lines");
    AST_BASE_WRITE: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_REG && wr_q && offset == OFS_WIN_BASE && base_loaded)
        |=> win_base == $past(d_in[7:0]) && !dtack_oe_n)
        else $error("Base register write lost");
    AST_LINK_GATE: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (fib_req && fib_addr >= OFS_CFG_LO && fib_addr <= OFS_CFG_HI)
        |=> !fib_grant)
        else $error("Link reached a VME-only register");
    AST_LINK_OFF_FIRST: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        loc_req |-> fiber_disable && $past(state) == ST_WAIT)
        else $error("Board access while link enabled");
    AST_A24_HIT: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_DEC && (am_a24 || am_a24_blt)
         && addr_q[23:18] == win_base[7:2])
        |=> space_q inside {SP_CFG, SP_A24})
        else $error("A24 window not decoded");
    AST_A32_OBUF: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_DEC && (am_a32 || am_mblt)
         && addr_q[31:23] == obuf_base[29:21])
        |=> space_q == SP_OBUF)
        else $error("Output buffer window not decoded");
    AST_SLAVE_END: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_LOC && loc_ack && loc_last && am_q == AM_2E)
        |=> !berr_oe_n && !dtack_oe_n
            ##1 (berr_oe_n == ($past(ds_n) == 2'h3)))
        else $error("Slave termination not signalled");
    AST_ACK_HOLD: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (!dtack_oe_n && ds_n != 2'h3) |=> !dtack_oe_n)
        else $error("Acknowledge dropped before strobe release");
endmodule // vme_slave_address_decode
`default_nettype wire

/* File: hw/window_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Upper address bits against a window base
interface window_if #(parameter int W = 6);
    logic [W-1:0] addr_hi;
    logic [W-1:0] base_hi;
    logic         hit;
    modport matcher (input addr_hi, input base_hi, output hit);
    modport user    (output addr_hi, output base_hi, input hit);
endinterface // window_if
`default_nettype wire

/* File: hw/window_match.sv */
`timescale 1ns/10ps
`default_nettype none
module window_match #(
    parameter int W = 6
) (
    // Window compare
    window_if.matcher win
);
    // Hit when every upper bit equals the base
    always_comb begin
        win.hit = (win.addr_hi == win.base_hi);
    end
endmodule // window_match
`default_nettype wire

/* File: verif/vme_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Crate controller driving single cycles
module vme_master_model (
    // Clock
    input  wire logic        sys_clk,
    // Driven bus lines
    output logic      [31:0] al_in,
    output logic      [5:0]  am_in,
    output logic             as_n,
    output logic      [1:0]  ds_n,
    output logic             write_n,
    output logic      [31:0] d_in,
    // Answer lines
    input  wire logic [31:0] d_o,
    input  wire logic        dtack_oe_n,
    input  wire logic        berr_oe_n
);
    // Idle bus at time zero
    initial begin
        al_in = 32'h0;
        am_in = 6'h0;
        as_n = 1'b1;
        ds_n = 2'b11;
        write_n = 1'b1;
        d_in = 32'h0;
    end

    // One cycle; resp 1 = acknowledge, 2 = bus error, 0 = none
    task automatic cycle(input logic [31:0] a, input logic [5:0] am,
        input logic wr, input logic [31:0] wd,
        output logic [31:0] rd, output logic [1:0] resp);
        int n;
        @(negedge sys_clk);
        al_in = a; // Byte 0 also carries the extended modifier
        am_in = am;
        write_n = ~wr;
        as_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        d_in = wr ? wd : ~d_in;
        ds_n = 2'b00;
        resp = 2'h0;
        rd = 32'h0;
        // Answer taken at the edge that shows it
        for (n = 0; n < 16 && resp == 2'h0; n++) begin
            @(posedge sys_clk);
            if (berr_oe_n === 1'b0) resp = 2'h2;
            else if (dtack_oe_n === 1'b0) resp = 2'h1;
            rd = d_o;
        end
        @(negedge sys_clk);
        ds_n = 2'b11;
        d_in = ~d_in; // Released lines lose the old value
        for (n = 0; n < 16 && (dtack_oe_n !== 1'b1 || berr_oe_n !== 1'b1);
             n++) @(negedge sys_clk);
        as_n = 1'b1;
        al_in = ~al_in;
    endtask
endmodule // vme_master_model
`default_nettype wire

/* File: verif/vme_slave_address_decode_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module vme_slave_address_decode_tb_top;
    import vme_decode_pkg::*;
    logic        sys_clk, arst_n, as_n, write_n, loc_ack, pend;
    logic        fib_req, fib_grant, parity, fdis, tdis, d_oe_n, al_oe_n;
    logic        dtack_oe_n, berr_oe_n, loc_req, loc_wr, cap_wr, last, frst;
    logic [31:0] al_in, d_in, d_o, al_o, rd;
    logic [5:0]  am_in;
    logic [1:0]  ds_n, resp;
    logic [3:0]  bank;
    logic [22:0] loc_addr, cap_addr;
    logic [63:0] loc_wdata, cap_wdata;
    logic [17:0] fib_addr;
    space_t      loc_space, cap_space;
    int          fails, check_count;

    vme_master_model i_vme_master_model (.sys_clk(sys_clk), .al_in(al_in),
        .am_in(am_in), .as_n(as_n), .ds_n(ds_n), .write_n(write_n),
        .d_in(d_in), .d_o(d_o), .dtack_oe_n(dtack_oe_n),
        .berr_oe_n(berr_oe_n));
    vme_slave_address_decode i_vme_slave_address_decode (.sys_clk(sys_clk),
        .arst_n(arst_n), .al_in(al_in), .al_o(al_o), .al_oe_n(al_oe_n),
        .am_in(am_in), .as_n(as_n), .ds_n(ds_n), .write_n(write_n),
        .d_in(d_in), .d_o(d_o), .d_oe_n(d_oe_n), .dtack_oe_n(dtack_oe_n),
        .berr_oe_n(berr_oe_n), .slot_position_lines(5'h05),
        .slot_position_parity(parity), .loc_req(loc_req), .loc_wr(loc_wr),
        .loc_space(loc_space), .loc_addr(loc_addr), .loc_wdata(loc_wdata),
        .loc_rdata(64'h0123456789abcdef), .loc_ack(loc_ack),
        .loc_last(last), .fib_req(fib_req), .fib_addr(fib_addr),
        .fib_grant(fib_grant), .fiber_disable(fdis), .tx_disable(tdis),
        .fiber_reset(frst), .sdram_bank(bank));

    // Clock and reset
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Board side answers on the falling edge one and a half cycles after each request
    always @(posedge sys_clk) begin
        pend <= loc_req;
        if (loc_req === 1'b1) begin
            cap_space <= loc_space;
            cap_addr <= loc_addr;
            cap_wr <= loc_wr;
            cap_wdata <= loc_wdata;
        end
    end
    always @(negedge sys_clk) loc_ack <= pend;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Board access through one modifier, then compare what came out
    task automatic run(input logic [5:0] am, input logic [31:0] a,
        input space_t sp, input logic ck);
        i_vme_master_model.cycle(a, am, 1'b0, 32'h0, rd, resp);
        chk(resp, 2'h1);
        chk(rd, 32'h89abcdef);
        chk(cap_space, sp);
        if (ck) chk(cap_addr, 23'h10);
    endtask
    // Link request held two cycles, grant compared
    task automatic link(input logic [17:0] a, input logic g);
        @(negedge sys_clk);
        fib_addr = a;
        fib_req = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(fib_grant, g);
        fib_req = 1'b0;
    endtask

    initial begin
        {fails, check_count, pend, loc_ack, fib_req, last} = '0;
        {parity, fib_addr, arst_n} = '0;
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
        // Base register after reset from slot 5
        i_vme_master_model.cycle(32'h280180, AM_A24_UD, 0, 0, rd, resp);
        chk(rd, 32'h28);
        parity = 1'b1;
        i_vme_master_model.cycle(32'h280010, AM_A24_UD, 0, 0, rd, resp);
        chk(resp, 2'h2);
        // Link off before board access, link also held in reset
        i_vme_master_model.cycle(32'h280190, AM_A24_UD, 1, 32'hb, rd,
            resp);
        chk({fdis, tdis, frst}, 3'b111);
        $display("reset and link control done");
        // Move the window and probe old and new places
        i_vme_master_model.cycle(32'h280180, AM_A24_UD, 1, 32'h40, rd,
            resp);
        i_vme_master_model.cycle(32'h280180, AM_A24_UD, 0, 0, rd, resp);
        chk(resp, 2'h0);
        i_vme_master_model.cycle(32'h400180, AM_A24_SD, 0, 0, rd, resp);
        chk(rd, 32'h40);
        run(AM_A24_UD, 32'h400010, SP_A24, 1);
        run(AM_A24_UP, 32'h400010, SP_A24, 1);
        run(AM_A24_SD, 32'h400010, SP_A24, 1);
        run(AM_A24_SP, 32'h400010, SP_A24, 1);
        run(AM_A24_UB, 32'h400010, SP_A24, 1);
        run(AM_A24_SB, 32'h400010, SP_A24, 1);
        run(AM_CRCSR, 32'h280010, SP_CRCSR, 0);
        $display("A24 window done");
        // A32 bases written, each window reached
        i_vme_master_model.cycle(32'h400194, AM_A24_UD, 1, 32'h08000000, rd,
            resp);
        i_vme_master_model.cycle(32'h400198, AM_A24_UD, 1, 32'h10000000, rd,
            resp);
        i_vme_master_model.cycle(32'h400188, AM_A24_UD, 1, 32'h18000000, rd,
            resp);
        run(AM_A32_UD, 32'h20000010, SP_OBUF, 1);
        run(AM_A32_UP, 32'h20000010, SP_OBUF, 1);
        run(AM_A32_SD, 32'h40000010, SP_SDRAM, 1);
        run(AM_A32_SP, 32'h40000010, SP_SDRAM, 1);
        run(AM_A32_UB, 32'h60000010, SP_TEST, 1);
        run(AM_A32_SB, 32'h60000010, SP_TEST, 1);
        i_vme_master_model.cycle(32'h20000010, AM_A32_UD, 1, 32'h5a5a0f0f, rd,
            resp);
        chk({resp, cap_wr, cap_wdata[31:0]}, {2'h1, 1'b1, 32'h5a5a0f0f});
        i_vme_master_model.cycle(32'h80000010, AM_A32_UD, 0, 0, rd,
            resp);
        chk(resp, 2'h0);
        // Multiplexed and two-edge cycles, high word on address lines
        run(AM_A32_UM, 32'h20000010, SP_OBUF, 1);
        run(AM_A32_SM, 32'h40000010, SP_SDRAM, 1);
        run(AM_2E, 32'h20000001, SP_OBUF, 0);
        chk(al_o, 32'h01234567);
        chk({al_oe_n, d_oe_n}, 2'b11);
        last = 1'b1;
        i_vme_master_model.cycle(32'h40000011, AM_2E, 0, 0, rd, resp);
        chk(resp, 2'h2);
        chk(cap_space, SP_SDRAM);
        last = 1'b0;
        i_vme_master_model.cycle(32'h40019c, AM_A24_UD, 1, 5, rd, resp);
        chk(bank, 4'h5);
        $display("A32 windows done");
        link(18'h00180, 1'b0);
        link(18'h0019c, 1'b0);
        link(18'h00100, 1'b1);
        $display("link gate done");
        test_done();
    end
    // Watchdog
    initial begin
        #2000000;
        fails++;
        test_done();
    end
endmodule // vme_slave_address_decode_tb_top
`default_nettype wire
